// ===== design/sep_pkg.sv
package sep_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 8;
  localparam int          MEM_DEPTH  = 256;
  localparam int          PAGE_BYTES = 4;

  // ----------------------------------------------------------------
  // Opcodes, sent MSB first
  // ----------------------------------------------------------------
  localparam logic [7:0]  OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0]  OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0]  OP_READ_STATUS       = 8'h05;
  localparam logic [7:0]  OP_WRITE_STATUS      = 8'h01;
  localparam logic [7:0]  OP_READ              = 8'h03;
  localparam logic [7:0]  OP_WRITE             = 8'h02;

  // ----------------------------------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------------------------------
  localparam int          ST_BUSY_BIT  = 0;
  localparam int          ST_LATCH_BIT = 1;
  localparam int          ST_PROT_LO   = 2;
  localparam int          ST_PROT_HI   = 3;
  localparam logic [7:0]  STATUS_BUSY  = 8'hFF;
  localparam logic [1:0]  PROT_RST     = 2'h0;

  // Protection thresholds for levels 01 and 10; level 11 covers all
  localparam logic [7:0]  PROT_QUARTER = 8'hC0;
  localparam logic [7:0]  PROT_HALF    = 8'h80;

  // ----------------------------------------------------------------
  // Serial clock counts and timing
  // ----------------------------------------------------------------
  localparam logic [6:0]  CNT_BYTE1  = 7'h08;
  localparam logic [6:0]  CNT_BYTE2  = 7'h10;
  localparam logic [6:0]  CNT_WR24   = 7'h18;
  localparam logic [6:0]  CNT_WR32   = 7'h20;
  localparam logic [6:0]  CNT_WR40   = 7'h28;
  localparam logic [6:0]  CNT_WR48   = 7'h30;
  localparam logic [6:0]  CNT_MAX    = 7'h7F;
  localparam int          CLK_HZ     = 40_000_000;
  localparam int          WC_TIME_MS = 10;
  // Longest time, so round down
  localparam int          WC_CYCLES  = (WC_TIME_MS * (CLK_HZ / 1000));

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
    logic hold_n;
  } sep_pins_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_OPCODE = 3'b001,
    S_ADDR   = 3'b010,
    S_RDATA  = 3'b011,
    S_WDATA  = 3'b100,
    S_STATUS = 3'b101,
    S_WSTAT  = 3'b110,
    S_LATCH  = 3'b111
  } sep_state_t;

endpackage

// ===== design/sep_eeprom_seq.sv
// How it works
// - Read opcode, address, then data shifts out
// - Address increments after each read byte
// - Read address wraps from top to zero
// - Chip select high ends the read
// - Latch set needs chip select high after eight
// - Page pointer wraps, overwriting loaded bytes
// - Write starts only at clock 24/32/40/48
// - Status reads all ones while busy
// - Pause input low freezes the transfer
// - Power-up: standby, output off, latch clear
// - Instruction only after chip select falls
// - Write-protect low clears the write latch
// - Internal write starts at select rise, 10 ms
// - Output off while paused, back after
// - Six opcodes, MSB first
// - Status: busy, latch, two protect bits
// - Protect levels none, quarter, half, all
// - Sample on rising edge, drive after falling
module sep_eeprom_seq #(
  parameter int WRITE_CYCLES = sep_pkg::WC_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  input  wire logic wp_n_i,
  input  wire logic hold_n_i,
  output logic      so_o,
  output logic      so_oe_o,
  output logic      busy_o
);

  localparam int WC_W = $clog2(WRITE_CYCLES + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  sep_pkg::sep_pins_t pin1_q;
  sep_pkg::sep_pins_t pin2_q;
  sep_pkg::sep_pins_t pin3_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin1_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
      pin2_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
      pin3_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
    end else begin
      pin1_q <= '{sck: sck_i, cs_n: cs_n_i, si: si_i, wp_n: wp_n_i,
                  hold_n: hold_n_i};
      pin2_q <= pin1_q;
      pin3_q <= pin2_q;
    end
  end

  logic active_q;
  logic cs_fall;
  logic cs_rise;
  logic run;
  logic sck_rise;
  logic sck_fall;
  assign cs_fall  = pin3_q.cs_n & ~pin2_q.cs_n;
  assign cs_rise  = ~pin3_q.cs_n & pin2_q.cs_n;
  // Paused clock edges are simply not seen, so no place is lost
  assign run      = active_q & pin2_q.hold_n;
  assign sck_rise = run & pin2_q.sck & ~pin3_q.sck;
  assign sck_fall = run & ~pin2_q.sck & pin3_q.sck;

  // Only a falling select wakes the sequencer after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_q <= 1'b0;
    end else if (cs_fall) begin
      active_q <= 1'b1;
    end else if (cs_rise) begin
      active_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Storage and protection
  // ----------------------------------------------------------------
  logic [sep_pkg::DATA_W-1:0] mem [sep_pkg::MEM_DEPTH];
  logic [1:0]                 prot_q;
  logic                       wel_q;
  logic                       busy_q;
  function automatic logic is_prot(input logic [1:0] lvl,
                                   input logic [7:0] a);
    return (lvl == 2'b11) ||
           (lvl == 2'b10 && a >= sep_pkg::PROT_HALF) ||
           (lvl == 2'b01 && a >= sep_pkg::PROT_QUARTER);
  endfunction

  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[sep_pkg::ST_BUSY_BIT]  = busy_q;
    status_byte[sep_pkg::ST_LATCH_BIT] = wel_q;
    status_byte[sep_pkg::ST_PROT_LO]   = prot_q[0];
    status_byte[sep_pkg::ST_PROT_HI]   = prot_q[1];
    if (busy_q) begin
      status_byte = sep_pkg::STATUS_BUSY;
    end
  end

  // ----------------------------------------------------------------
  // Serial command sequencer
  // ----------------------------------------------------------------
  sep_pkg::sep_state_t state_q;
  logic [6:0]          cnt_q;
  logic [6:0]          sr_q;
  logic [7:0]          addr_q;
  logic [7:0]          out_q;
  logic [7:0]          pbuf_q [sep_pkg::PAGE_BYTES];
  logic [3:0]          pval_q;
  logic [1:0]          wptr_q;
  logic                rd_op_q;
  logic [1:0]          prot_new_q;
  logic [7:0]          rx_byte;
  logic                byte_done;
  logic [7:0]          addr_nx;
  assign rx_byte   = {sr_q, pin2_q.si};
  assign byte_done = sck_rise & (cnt_q[2:0] == 3'h7);
  assign addr_nx   = addr_q + 8'h01;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q    <= sep_pkg::S_IDLE;
      cnt_q      <= 7'h00;
      sr_q       <= 7'h00;
      addr_q     <= 8'h00;
      out_q      <= 8'h00;
      pval_q     <= 4'h0;
      wptr_q     <= 2'h0;
      rd_op_q    <= 1'b0;
      prot_new_q <= sep_pkg::PROT_RST;
      pbuf_q     <= '{default: 8'h00};
    end else if (cs_fall) begin
      state_q <= sep_pkg::S_OPCODE;
      cnt_q   <= 7'h00;
    end else if (cs_rise) begin
      state_q <= sep_pkg::S_IDLE;
    end else if (sck_rise) begin
      sr_q <= rx_byte[6:0];
      if (cnt_q != sep_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + 7'h01;
      end
      if (byte_done) begin
        case (state_q)
          sep_pkg::S_OPCODE: begin
            if (rx_byte == sep_pkg::OP_READ_STATUS) begin
              state_q <= sep_pkg::S_STATUS;
              out_q   <= status_byte;
            end else if (busy_q) begin
              state_q <= sep_pkg::S_IDLE;
            end else if (rx_byte == sep_pkg::OP_SET_WRITE_LATCH) begin
              state_q <= sep_pkg::S_LATCH;
            end else if (rx_byte == sep_pkg::OP_WRITE_STATUS) begin
              state_q <= sep_pkg::S_WSTAT;
            end else if (rx_byte == sep_pkg::OP_READ ||
                         rx_byte == sep_pkg::OP_WRITE) begin
              state_q <= sep_pkg::S_ADDR;
              rd_op_q <= (rx_byte == sep_pkg::OP_READ);
            end else begin
              state_q <= sep_pkg::S_IDLE;
            end
          end
          sep_pkg::S_ADDR: begin
            addr_q <= rx_byte;
            wptr_q <= rx_byte[1:0];
            pval_q <= 4'h0;
            if (rd_op_q) begin
              state_q <= sep_pkg::S_RDATA;
              out_q   <= mem[rx_byte];
            end else begin
              state_q <= sep_pkg::S_WDATA;
            end
          end
          sep_pkg::S_RDATA: begin
            addr_q <= addr_nx;
            out_q  <= mem[addr_nx];
          end
          sep_pkg::S_STATUS: begin
            out_q <= status_byte;
          end
          sep_pkg::S_WDATA: begin
            // Pointer stays inside the page and overwrites on wrap
            pbuf_q[wptr_q] <= rx_byte;
            pval_q[wptr_q] <= 1'b1;
            wptr_q         <= wptr_q + 2'h1;
          end
          sep_pkg::S_WSTAT: begin
            prot_new_q <= rx_byte[sep_pkg::ST_PROT_HI:sep_pkg::ST_PROT_LO];
          end
          default: begin
            state_q <= sep_pkg::S_IDLE;
          end
        endcase
      end
    end else if (sck_fall && (state_q == sep_pkg::S_RDATA ||
                              state_q == sep_pkg::S_STATUS)) begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Serial output: driven after falling edges, off when idle or paused
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      so_oe_o <= run & ~cs_rise & (state_q == sep_pkg::S_RDATA ||
                 state_q == sep_pkg::S_STATUS);
      if (sck_fall && (state_q == sep_pkg::S_RDATA ||
                       state_q == sep_pkg::S_STATUS)) begin
        so_o <= out_q[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write latch, protection bits and self-timed write
  // ----------------------------------------------------------------
  logic [WC_W-1:0] wc_q;
  logic            cnt_ok;
  logic            commit_wr;
  logic            commit_set_write_latch_cmd;
  logic            commit_wsr;
  logic            clear_write_latch_cmd_hit;
  logic            wc_done;
  assign cnt_ok = cnt_q inside {sep_pkg::CNT_WR24, sep_pkg::CNT_WR32,
                                sep_pkg::CNT_WR40, sep_pkg::CNT_WR48};
  // Write-protect low at the select rise abandons the write
  assign commit_wr   = cs_rise & active_q & ~busy_q & wel_q & pin2_q.wp_n &
                       (state_q == sep_pkg::S_WDATA) & cnt_ok;
  assign commit_set_write_latch_cmd = cs_rise & active_q & ~busy_q &
                       (state_q == sep_pkg::S_LATCH) &
                       (cnt_q == sep_pkg::CNT_BYTE1);
  assign commit_wsr  = cs_rise & active_q & ~busy_q & wel_q & pin2_q.wp_n &
                       (state_q == sep_pkg::S_WSTAT) &
                       (cnt_q == sep_pkg::CNT_BYTE2);
  assign clear_write_latch_cmd_hit    = byte_done & ~busy_q & (state_q == sep_pkg::S_OPCODE) &
                       (rx_byte == sep_pkg::OP_CLEAR_WRITE_LATCH);
  assign wc_done     = busy_q & (wc_q == '0);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wel_q <= 1'b0;
    end else if (!pin2_q.wp_n) begin
      wel_q <= 1'b0;
    end else if (commit_set_write_latch_cmd) begin
      wel_q <= 1'b1;
    end else if (clear_write_latch_cmd_hit || wc_done || commit_wsr) begin
      wel_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prot_q <= sep_pkg::PROT_RST;
    end else if (commit_wsr) begin
      prot_q <= prot_new_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      wc_q   <= '0;
    end else if (commit_wr) begin
      busy_q <= 1'b1;
      wc_q   <= WC_W'(WRITE_CYCLES - 1);
    end else if (wc_done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      wc_q <= wc_q - WC_W'(1);
    end
  end

  // Array update lands at the commit; busy only models the cell time
  always_ff @(posedge clk_i) begin
    if (commit_wr) begin
      for (int i = 0; i < sep_pkg::PAGE_BYTES; i++) begin
        if (pval_q[i] &&
            !is_prot(prot_q, {addr_q[7:2], 2'(i)})) begin
          mem[{addr_q[7:2], 2'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

  assign busy_o  = busy_q;

endmodule

// ===== testbench/sep_eeprom_seq_asserts.sv
module sep_eeprom_seq_asserts #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [31:0] busy_len_q;

  // Length of the current busy period, checked when it ends
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_len_q <= '0;
    else if (busy_o) busy_len_q <= busy_len_q + 32'h0000_0001;
    else busy_len_q <= '0;
  end

  reset_quiet_a: assert property ($rose(rst_n_i) |-> !so_oe_o && !busy_o)
    else $error("output enable or busy active after reset");
  deselect_off_a: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("output still driven while deselected");
  pause_off_a: assert property (!hold_n_i [*6] |-> !so_oe_o)
    else $error("output still driven while paused");
  drive_needs_sel_a: assert property ($rose(so_oe_o) |-> !cs_n_i && hold_n_i)
    else $error("output enabled without select");
  out_on_low_a: assert property (
    $changed(so_o) && so_oe_o && $past(so_oe_o) |-> !sck_i)
    else $error("serial output changed while clock high");
  busy_start_a: assert property ($rose(busy_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("busy rose without select release");
  busy_hold_a: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("busy period cut short");
  busy_len_a: assert property ($fell(busy_o) |->
    busy_len_q + 1 >= WRITE_CYCLES && busy_len_q <= WRITE_CYCLES + 1)
    else $error("busy period length wrong");
endmodule

bind sep_eeprom_seq sep_eeprom_seq_asserts #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
  .si_i(si_i), .wp_n_i(wp_n_i), .hold_n_i(hold_n_i), .so_o(so_o),
  .so_oe_o(so_oe_o), .busy_o(busy_o));

// ===== testbench/sep_host.sv
module sep_host (
  input  wire logic clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      hold_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic start();
    wait_clk(1);
    cs_n_o = 1'b0;
    wait_clk(4);
  endtask

  // Data line is not held after release: show the inverse instead
  task automatic stop();
    cs_n_o = 1'b1;
    si_o = ~si_o;
    wait_clk(8);
  endtask

  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = tx[i];
      wait_clk(4);
      rx = {rx[6:0], so_oe_i ? so_i : 1'bz};
      sck_o = 1'b1;
      wait_clk(4);
      sck_o = 1'b0;
    end
  endtask

  // Only called with the serial clock low; the settle time keeps the
  // last clock fall ahead of the pause edge at the device
  task automatic pause(input logic lvl);
    wait_clk(4);
    hold_n_o = lvl;
    wait_clk(6);
  endtask
endmodule

// ===== testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCYC = 400;
  logic       clk;
  logic       rst_n;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       wp_n;
  logic       hold_n;
  logic       so;
  logic       so_oe;
  logic       busy;
  logic [7:0] d;
  logic [7:0] s;
  int         fails = 0;
  int         total_checks = 0;
  int         cycles = 0;

  sep_eeprom_seq #(.WRITE_CYCLES(WCYC)) i_dut (.clk_i(clk), .rst_n_i(rst_n),
    .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n), .hold_n_i(hold_n),
    .so_o(so), .so_oe_o(so_oe), .busy_o(busy));
  sep_host i_host (.clk_i(clk), .so_i(so), .so_oe_i(so_oe), .sck_o(sck),
    .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, well above the length of the whole sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      test_done();
    end
  end

  task automatic op(input logic [7:0] o);
    i_host.start();
    i_host.xfer(o, 8, d);
    i_host.stop();
  endtask

  task automatic status(input logic [7:0] e);
    i_host.start();
    i_host.xfer(sep_pkg::OP_READ_STATUS, 8, d);
    i_host.xfer(8'h00, 8, s);
    i_host.stop();
    chk("status", e, s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] b[$], input int nb);
    op(sep_pkg::OP_SET_WRITE_LATCH);
    i_host.start();
    i_host.xfer(sep_pkg::OP_WRITE, 8, d);
    i_host.xfer(a, 8, d);
    foreach (b[i]) i_host.xfer(b[i], 8, d);
    if (nb > 0) i_host.xfer(8'h0F, nb, d);
    i_host.stop();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
    i_host.start();
    i_host.xfer(sep_pkg::OP_READ, 8, d);
    i_host.xfer(a, 8, d);
    foreach (e[i]) begin
      i_host.xfer(8'h00, 8, s);
      chk("read", e[i], s);
    end
    i_host.stop();
  endtask

  task automatic wait_idle();
    for (int n = 0; n < WCYC + 100 && busy !== 1'b0; n++) @(negedge clk);
    chk("busy", 8'h00, {7'h00, busy});
  endtask

  task automatic set_prot(input logic [7:0] v);
    op(sep_pkg::OP_SET_WRITE_LATCH);
    i_host.start();
    i_host.xfer(sep_pkg::OP_WRITE_STATUS, 8, d);
    i_host.xfer(v, 8, d);
    i_host.stop();
  endtask

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("oe", 8'h00, {7'h00, so_oe});
    status(8'h00);
    op(sep_pkg::OP_SET_WRITE_LATCH);
    status(8'h02);
    op(sep_pkg::OP_CLEAR_WRITE_LATCH);
    status(8'h00);
    $display("test latch finished");
    wr(8'hFD, {8'h11, 8'h22, 8'h33, 8'h44}, 0);
    chk("busy", 8'h01, {7'h00, busy});
    status(8'hFF);
    wait_idle();
    status(8'h00);
    wr(8'h00, {8'h5A}, 0);
    wait_idle();
    rd(8'hFE, {8'h22, 8'h33, 8'h5A});
    rd(8'hFC, {8'h44, 8'h11});
    $display("test write read finished");
    wr(8'h00, {8'hA5}, 4);
    chk("busy", 8'h00, {7'h00, busy});
    i_host.start();
    i_host.xfer(sep_pkg::OP_SET_WRITE_LATCH, 8, d);
    i_host.xfer(sep_pkg::OP_WRITE, 8, d);
    i_host.xfer(8'h00, 8, d);
    i_host.xfer(8'h77, 8, d);
    i_host.stop();
    chk("busy", 8'h00, {7'h00, busy});
    rd(8'h00, {8'h5A});
    op(sep_pkg::OP_SET_WRITE_LATCH);
    wp_n = 1'b0;
    repeat (6) @(negedge clk);
    wp_n = 1'b1;
    status(8'h00);
    $display("test refusals finished");
    set_prot(8'h0C);
    status(8'h0C);
    wr(8'hFC, {8'h99}, 0);
    wait_idle();
    i_host.start();
    i_host.xfer(sep_pkg::OP_READ, 8, d);
    i_host.xfer(8'hFC, 8, d);
    i_host.xfer(8'h00, 4, d);
    i_host.pause(1'b0);
    chk("oe", 8'h00, {7'h00, so_oe});
    i_host.pause(1'b1);
    chk("oe", 8'h01, {7'h00, so_oe});
    i_host.xfer(8'h00, 4, s);
    i_host.stop();
    chk("read", 8'h44, {d[3:0], s[3:0]});
    $display("test protect pause finished");
    set_prot(8'h00);
    status(8'h00);
    wr(8'h80, {8'h21}, 0);
    wait_idle();
    wr(8'hC0, {8'h22}, 0);
    wait_idle();
    set_prot(8'h04);
    status(8'h04);
    wr(8'h80, {8'h31}, 0);
    wait_idle();
    wr(8'hC0, {8'h32}, 0);
    wait_idle();
    set_prot(8'h08);
    status(8'h08);
    wr(8'h7F, {8'h41}, 0);
    wait_idle();
    wr(8'h80, {8'h42}, 0);
    wait_idle();
    rd(8'h7F, {8'h41, 8'h31});
    rd(8'hC0, {8'h22});
    $display("test protect levels finished");
    test_done();
  end
endmodule
